// ==== src/iout_fault_map.vh ====
`ifndef IOUT_FAULT_MAP_VH
`define IOUT_FAULT_MAP_VH

// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_OC_ACTION      8'he5
`define CMD_UC_ACTION      8'he6

// ****************************************************************
// Action register fields and reset value
// ****************************************************************
`define ACTION_RESET       8'h80
`define RESP_HI            7
`define RESP_LO            6
`define RETRY_HI           5
`define RETRY_LO           3
`define DELAY_HI           2
`define DELAY_LO           0
`define RESP_SHUTDOWN      2'h2
`define RETRY_NONE         3'h0
`define RETRY_FOREVER      3'h7

// ****************************************************************
// Status byte bit positions
// ****************************************************************
`define STAT_OC_BIT        7
`define STAT_UC_BIT        6

// ****************************************************************
// Timing
// ****************************************************************
`define RETRY_UNIT_US      35000
`define CLK_PERIOD_NS      100
`define NS_PER_US          1000

`endif

// ==== src/retry_tick.v ====
`timescale 1ns/1ps
`include "iout_fault_map.vh"

// Free running divider giving one-cycle pulses, restartable so an
// interval can be measured from an exact instant
module retry_tick #(
  parameter TICK_CYCLES = (`RETRY_UNIT_US * `NS_PER_US) / `CLK_PERIOD_NS,
  parameter CW          = 20
) (
  // Clock and reset
  input  wire          ref_clk,
  input  wire          rst_sync_b,
  // Control
  input  wire          restart,
  output reg           tick
);

  reg  [CW-1:0]        count;
  localparam integer   LAST_INT = TICK_CYCLES - 1;
  localparam [CW-1:0]  LAST     = LAST_INT[CW-1:0];

  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count <= {CW{1'b0}};
      tick  <= 1'b0;
    end else if (restart) begin
      // Restart edge is the first cycle of the interval; needs two or more cycles per tick
      count <= {{(CW-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end else if (count == LAST) begin
      count <= {CW{1'b0}};
      tick  <= 1'b1;
    end else begin
      count <= count + {{(CW-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end

endmodule // retry_tick

// ==== src/output_current_fault_response.v ====
`timescale 1ns/1ps
`include "iout_fault_map.vh"

module output_current_fault_response #(
  parameter TICK_CYCLES = (`RETRY_UNIT_US * `NS_PER_US) / `CLK_PERIOD_NS,
  parameter TICK_W      = 20
) (
  // Clock and reset
  input  wire          ref_clk,
  input  wire          rst_b,
  // Command port
  input  wire          cmd_valid,
  input  wire          cmd_write,
  input  wire [7:0]    cmd_code,
  input  wire [7:0]    cmd_wdata,
  input  wire          clear_faults,
  output reg  [7:0]    cmd_rdata,
  // Fault detectors and system conditions
  input  wire          oc_fault_det,
  input  wire          uc_fault_det,
  input  wire          output_on_cmd,
  input  wire          bias_ok,
  input  wire          other_fault_shutdown,
  // Status and control outputs
  output reg  [7:0]    status_iout,
  output reg           alert_out_n,
  output reg           output_enable,
  output reg           restart_pulse
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  reg                  rst_meta_b;
  reg                  rst_sync_b;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_IDLE    = 3'h0;
  localparam [2:0] ST_RUN     = 3'h1;
  localparam [2:0] ST_LATCHED = 3'h2;
  localparam [2:0] ST_WAIT    = 3'h3;
  localparam [2:0] ST_ATTEMPT = 3'h4;

  reg  [2:0]           state;
  reg  [2:0]           next_state;
  reg  [7:0]           oc_action;
  reg  [7:0]           uc_action;
  reg  [7:0]           active_action;
  reg  [7:0]           next_active_action;
  reg  [3:0]           ticks_left;
  reg  [3:0]           next_ticks_left;
  reg                  next_enable;
  reg                  next_restart;
  reg                  timer_restart;
  wire                 tick;

  // Interval in whole ticks, field value plus one
  function [3:0] interval_ticks;
    input [7:0] action;
    begin
      interval_ticks = {1'b0, action[`DELAY_HI:`DELAY_LO]} + 4'h1;
    end
  endfunction

  function retries_forever;
    input [7:0] action;
    begin
      retries_forever = (action[`RETRY_HI:`RETRY_LO] == `RETRY_FOREVER);
    end
  endfunction

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  wire wr_oc = cmd_valid && cmd_write && (cmd_code == `CMD_OC_ACTION);
  wire wr_uc = cmd_valid && cmd_write && (cmd_code == `CMD_UC_ACTION);

  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      oc_action <= `ACTION_RESET;
      uc_action <= `ACTION_RESET;
      cmd_rdata <= 8'h00;
    end else begin
      if (wr_oc)
        oc_action <= cmd_wdata;
      if (wr_uc)
        uc_action <= cmd_wdata;
      if (cmd_valid && !cmd_write) begin
        case (cmd_code)
          `CMD_OC_ACTION: cmd_rdata <= oc_action;
          `CMD_UC_ACTION: cmd_rdata <= uc_action;
          default:        cmd_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // Fault capture
  // ****************************************************************
  // Faults only count while the output is actually on
  wire oc_hit    = output_enable && oc_fault_det;
  wire uc_hit    = output_enable && uc_fault_det;
  wire fault_hit = oc_hit || uc_hit;
  wire stop_req  = !output_on_cmd || !bias_ok || other_fault_shutdown;

  reg  [7:0]           next_status;

  always @* begin
    next_status = status_iout;
    if (clear_faults)
      next_status = 8'h00;
    // Set beats a simultaneous clear
    if (oc_hit)
      next_status[`STAT_OC_BIT] = 1'b1;
    if (uc_hit)
      next_status[`STAT_UC_BIT] = 1'b1;
  end

  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      status_iout <= 8'h00;
      alert_out_n <= 1'b1;
    end else begin
      status_iout <= next_status;
      alert_out_n <= !(next_status[`STAT_OC_BIT] || next_status[`STAT_UC_BIT]);
    end
  end

  // ****************************************************************
  // Response sequencer
  // ****************************************************************
  always @* begin
    next_state         = state;
    next_active_action = active_action;
    next_ticks_left    = ticks_left;
    next_enable        = output_enable;
    next_restart       = 1'b0;
    timer_restart      = 1'b0;
    case (state)
      ST_IDLE: begin
        next_enable = 1'b0;
        if (!stop_req) begin
          next_state  = ST_RUN;
          next_enable = 1'b1;
        end
      end
      ST_RUN: begin
        if (fault_hit) begin
          // Overcurrent action wins when both fire together
          next_active_action = oc_hit ? oc_action : uc_action;
          next_enable        = 1'b0;
          if (retries_forever(next_active_action)) begin
            next_state      = ST_WAIT;
            next_ticks_left = interval_ticks(next_active_action);
            timer_restart   = 1'b1;
          end else begin
            next_state = ST_LATCHED;
          end
        end else if (stop_req) begin
          next_state  = ST_IDLE;
          next_enable = 1'b0;
        end
      end
      ST_LATCHED: begin
        next_enable = 1'b0;
        if (clear_faults)
          next_state = ST_IDLE;
      end
      ST_WAIT, ST_ATTEMPT: begin
        if (stop_req) begin
          next_state  = ST_IDLE;
          next_enable = 1'b0;
        end else begin
          if (fault_hit) begin
            next_enable = 1'b0;
            next_state  = ST_WAIT;
          end
          if (tick) begin
            if (ticks_left == 4'h1) begin
              if (state == ST_ATTEMPT && !fault_hit) begin
                next_state = ST_RUN;
              end else if (fault_hit) begin
                // Shutdown wins over the return to ST_RUN due in the same cycle
                next_ticks_left = interval_ticks(active_action);
                timer_restart   = 1'b1;
              end else begin
                // Fault not rechecked before each attempt
                next_state      = ST_ATTEMPT;
                next_enable     = 1'b1;
                next_restart    = 1'b1;
                next_ticks_left = interval_ticks(active_action);
                timer_restart   = 1'b1;
              end
            end else begin
              next_ticks_left = ticks_left - 4'h1;
            end
          end
        end
      end
      default: begin
        next_state  = ST_IDLE;
        next_enable = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state         <= ST_IDLE;
      active_action <= `ACTION_RESET;
      ticks_left    <= 4'h0;
      output_enable <= 1'b0;
      restart_pulse <= 1'b0;
    end else begin
      state         <= next_state;
      active_action <= next_active_action;
      ticks_left    <= next_ticks_left;
      output_enable <= next_enable;
      restart_pulse <= next_restart;
    end
  end

  // ****************************************************************
  // Retry time base
  // ****************************************************************
  retry_tick #(
    .TICK_CYCLES (TICK_CYCLES),
    .CW          (TICK_W)
  ) u_retry_tick (
    .ref_clk     (ref_clk),
    .rst_sync_b  (rst_sync_b),
    .restart     (timer_restart),
    .tick        (tick)
  );

endmodule // output_current_fault_response

// ==== bench/host_model.sv ====
`timescale 1ns/1ps
// ****************************
// Host side of the command port
// ****************************
module host_model (
  // Clock and read data
  input  wire logic       ref_clk,
  input  wire logic [7:0] cmd_rdata,
  // Command strobes
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic            clear_faults,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_wdata
);
  initial begin
    {cmd_valid, cmd_write, clear_faults, cmd_code, cmd_wdata} = 19'h0;
  end
  // Idle bus shows inverted data so stale values never pass
  task xfer(input logic w, input logic [7:0] c, input logic [7:0] v, output logic [7:0] r);
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, v};
    @(posedge ref_clk);
    #10;
    r = cmd_rdata;
    {cmd_valid, cmd_code, cmd_wdata} = {1'b0, ~c, ~v};
    // Idle edge keeps back-to-back strobes apart
    @(posedge ref_clk);
    #10;
  endtask
  task clr();
    clear_faults = 1'b1;
    @(posedge ref_clk);
    #10;
    clear_faults = 1'b0;
  endtask
endmodule // host_model

// ==== bench/output_current_fault_response_sva.sv ====
`timescale 1ns/1ps
module output_current_fault_response_sva #(parameter TICK_CYCLES = 350000, parameter TICK_W = 20) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // Command port
  input wire logic       cmd_valid,
  input wire logic       cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire logic       clear_faults,
  input wire logic [7:0] cmd_rdata,
  // Conditions
  input wire logic       oc_fault_det,
  input wire logic       uc_fault_det,
  input wire logic       output_on_cmd,
  input wire logic       bias_ok,
  input wire logic       other_fault_shutdown,
  // Outputs
  input wire logic [7:0] status_iout,
  input wire logic       alert_out_n,
  input wire logic       output_enable,
  input wire logic       restart_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [31:0] since;
  // Saturates so the first attempt after reset never looks early
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) since <= 32'hffffffff;
    else if (restart_pulse) since <= 32'h1;
    else if (since != 32'hffffffff) since <= since + 32'h1;
  end
  wire bad = !output_on_cmd || !bias_ok || other_fault_shutdown;
  property p_shut; output_enable && (oc_fault_det || uc_fault_det) |=> !output_enable && !alert_out_n; endproperty
  property p_alert; status_iout != 8'h00 |-> !alert_out_n; endproperty
  property p_sticky; status_iout[7] && !clear_faults |=> status_iout[7]; endproperty
  property p_oc; output_enable && oc_fault_det |=> status_iout[7]; endproperty
  property p_uc; output_enable && uc_fault_det |=> status_iout[6]; endproperty
  property p_stop; bad |=> !output_enable; endproperty
  property p_pulse; restart_pulse |-> output_enable ##1 !restart_pulse; endproperty
  property p_gap; restart_pulse |-> since >= TICK_CYCLES; endproperty
  a_shut: assert property (p_shut) else $error("output not cut on fault");
  a_alert: assert property (p_alert) else $error("alert not low with status set");
  a_sticky: assert property (p_sticky) else $error("status bit lost");
  a_oc: assert property (p_oc) else $error("overcurrent bit not set");
  a_uc: assert property (p_uc) else $error("undercurrent bit not set");
  a_stop: assert property (p_stop) else $error("output on while stopped");
  a_pulse: assert property (p_pulse) else $error("restart pulse malformed");
  a_gap: assert property (p_gap) else $error("restart too soon");
  c_retry: cover property (restart_pulse);
  c_uc: cover property (status_iout[6]);
  c_clr: cover property (clear_faults ##1 alert_out_n);
endmodule // output_current_fault_response_sva

// ==== bench/output_current_fault_response_bench.sv ====
`timescale 1ns/1ps
module output_current_fault_response_bench;
  localparam TC = 10;
  logic ref_clk = 0, rst_b = 0, oc = 0, uc = 0, on = 0, bias = 0, other = 0;
  wire cmd_valid, cmd_write, clear_faults, alert_out_n, output_enable, restart_pulse;
  wire [7:0] cmd_code, cmd_wdata, cmd_rdata, status_iout;
  integer n_fail = 0, total_checks = 0, n, i, g;
  logic [7:0] lfsr = 8'h62, d, r;
  always #50 ref_clk = ~ref_clk;
  output_current_fault_response #(.TICK_CYCLES(TC)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .clear_faults(clear_faults), .cmd_rdata(cmd_rdata), .oc_fault_det(oc), .uc_fault_det(uc),
    .output_on_cmd(on), .bias_ok(bias), .other_fault_shutdown(other), .status_iout(status_iout),
    .alert_out_n(alert_out_n), .output_enable(output_enable), .restart_pulse(restart_pulse));
  host_model host (.ref_clk(ref_clk), .cmd_rdata(cmd_rdata), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .clear_faults(clear_faults), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function logic [7:0] next_rand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function integer gap_of(input logic [2:0] v);
    return (v + 1) * TC;
  endfunction
  task cyc(input integer k);
    repeat (k) @(posedge ref_clk);
    #10;
  endtask
  task wait_pulse();
    n = 0;
    do begin cyc(1); n++; end while (!restart_pulse && n < 2000);
    chk({7'h0, n == g}, 8'h01);
  endtask
  task complete_run();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #10 rst_b = 1;
    cyc(3);
    host.xfer(0, 8'he5, 8'h00, r); chk(r, 8'h80);
    host.xfer(0, 8'he6, 8'h00, r); chk(r, 8'h80);
    host.xfer(0, 8'he7, 8'h00, r); chk(r, 8'h00);
    for (i = 0; i < 3; i++) begin
      lfsr = next_rand(lfsr);
      d = {5'b10111, i == 0 ? 3'h7 : lfsr[2:0]};
      g = gap_of(d[2:0]);
      host.xfer(1, 8'he5, d, r);
      host.xfer(0, 8'he5, 8'h00, r); chk(r, d);
      {on, bias, other} = 3'b110;
      cyc(3); chk(output_enable, 1);
      oc = 1; cyc(1); oc = 0;
      chk(output_enable, 0); chk(status_iout, 8'h80); chk(alert_out_n, 0);
      wait_pulse();
      oc = 1;
      wait_pulse();
      oc = 0;
      {on, bias, other} = i == 0 ? 3'b010 : i == 1 ? 3'b100 : 3'b111;
      cyc(2); chk(output_enable, 0);
      n = 0;
      repeat (2 * g) begin cyc(1); n += restart_pulse; end
      chk(n[7:0], 0); chk(status_iout, 8'h80);
      host.clr(); chk(status_iout, 8'h00); chk(alert_out_n, 1);
    end
    {on, bias, other} = 3'b110;
    cyc(3);
    uc = 1; cyc(1); uc = 0;
    chk(status_iout, 8'h40); chk(output_enable, 0);
    n = 0;
    repeat (100) begin cyc(1); n += output_enable | restart_pulse; end
    chk(n[7:0], 0);
    host.clr(); cyc(1); chk(output_enable, 1); chk(status_iout, 8'h00);
    complete_run();
  end
endmodule // output_current_fault_response_bench
bind output_current_fault_response output_current_fault_response_sva #(.TICK_CYCLES(TICK_CYCLES), .TICK_W(TICK_W))
  chk_i (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
  .cmd_wdata(cmd_wdata), .clear_faults(clear_faults), .cmd_rdata(cmd_rdata), .oc_fault_det(oc_fault_det),
  .uc_fault_det(uc_fault_det), .output_on_cmd(output_on_cmd), .bias_ok(bias_ok),
  .other_fault_shutdown(other_fault_shutdown), .status_iout(status_iout), .alert_out_n(alert_out_n),
  .output_enable(output_enable), .restart_pulse(restart_pulse));
